// File: inc/etxd_consts.svh
// Descriptor field positions, offsets, codes and CRC constants of the transmit descriptor engine
`ifndef ETXD_CONSTS_SVH
`define ETXD_CONSTS_SVH
// Word 0 control bits
`define ETXD_OWN_BIT      31
`define ETXD_LS_BIT       29
`define ETXD_FS_BIT       28
`define ETXD_STAMP_BIT    17
// Word 1 fields
`define ETXD_SA_SEL_BIT   31
`define ETXD_SA_MODE_HI   30
`define ETXD_SA_MODE_LO   29
`define ETXD_LEN_HI       12
// Source address modes
`define ETXD_SA_KEEP      2'h0
`define ETXD_SA_INSERT    2'h1
`define ETXD_SA_REPLACE   2'h2
// Byte offsets of descriptor words
`define ETXD_OFS_W0       32'h0000_0000
`define ETXD_OFS_W1       32'h0000_0004
`define ETXD_OFS_W2       32'h0000_0008
`define ETXD_OFS_W3       32'h0000_000C
`define ETXD_OFS_W6       32'h0000_0018
`define ETXD_OFS_W7       32'h0000_001C
// Frame layout
`define ETXD_SA_POS       16'h0006
`define ETXD_SA_END       16'h000C
`define ETXD_FCS_LEN      13'h0004
`define ETXD_POS_MAX      16'hFFFF
// CRC-32, reflected form
`define ETXD_CRC_INIT     32'hFFFF_FFFF
`define ETXD_CRC_POLY     32'hEDB8_8320
`endif

// File: inc/etxd_pkg.sv
// Types shared by the transmit descriptor engine
package etxd_pkg;
  // Gray codes along fetch, emit and write-back path
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_RD0   = 4'h1,
    ST_RD1   = 4'h3,
    ST_RD2   = 4'h2,
    ST_RD3   = 4'h6,
    ST_FETCH = 4'h7,
    ST_EMIT  = 4'h5,
    ST_STAMP = 4'h4,
    ST_WR6   = 4'hC,
    ST_WR7   = 4'hD,
    ST_WR0   = 4'hF
  } etxd_state_t;

  // Controller state
  typedef struct packed {
    etxd_state_t st;
    logic        busy;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] desc_addr;
    logic [31:0] w0;
    logic [12:0] remain;
    logic [31:0] buf_addr;
    logic [31:0] next_ptr;
    logic [31:0] word;
    logic [15:0] pos;
    logic [31:0] crc;
    logic        modify;
    logic        insert;
    logic        sa_sel;
    logic        stamp_cap;
    logic [63:0] stamp;
  } etxd_ctl_t;

  // Output stage towards the transmitter
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } etxd_out_t;
endpackage : etxd_pkg

// File: rtl/etxd_desc_engine.sv
// Transmit descriptor engine: descriptor fetch, source address insertion, CRC, stamp write-back
`timescale 1ns/100ps
`include "etxd_consts.svh"

// ************************************************************
// Byte FIFO between descriptor engine and transmitter
// ************************************************************
module etxd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  // Pointer and fill update; full stalls the engine
  always_comb begin
    in_ready    = (count != (AW+1)'(DEPTH));
    out_valid   = (count != '0);
    out_data    = store[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1)) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1)) : rd_ptr;
    next_count  = (AW+1)'(count + push - pop);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage carries no reset, data only
  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule : etxd_fifo

// ************************************************************
// Descriptor engine
// ************************************************************
// Summary of operation
// - Word 1 bit 31 picks station address 1 or 0 as the source address used.
// - Word 1 bits 30:29 give 00 keep, 01 insert, 10 replace the source address, 11 reserved.
// - A frame whose source address was changed gets a freshly computed CRC in place of the old one.
// - The source address control field is honoured only in a first-segment descriptor.
// - Word 1 bits 12:0 give the first buffer length in bytes.
// - A zero first buffer length skips the buffer and moves on.
// - Word 2 is the 32-bit address of the first buffer.
// - Word 3 is the 32-bit address of the next descriptor in the chain.
// - The low 32 stamp bits are written to word 6.
// - The high 32 stamp bits are written to word 7.
// - Stamp words are written only for a last-segment descriptor with a captured stamp.
module etxd_desc_engine
  import etxd_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [31:0] desc_base,
  output logic             busy,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  input  wire logic [47:0] station_addr0,
  input  wire logic [47:0] station_addr1,
  input  wire logic        stamp_valid,
  input  wire logic        stamp_ok,
  input  wire logic [63:0] stamp_value,
  output logic             tx_valid,
  output logic             tx_last,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready
);
  etxd_ctl_t   c, n;
  etxd_out_t   o, next_o;
  logic        fin_valid, fin_ready, fout_valid, fout_ready;
  logic [8:0]  fin_data, fout_data;
  logic        issue, done, sa_slot, ins, fcs, ls, last;
  logic [1:0]  fcs_idx;
  logic [2:0]  sa_idx;
  logic [7:0]  lane_byte, sa_byte, crc_byte, out_byte;
  logic [47:0] sa_word;

  // One byte step of the reflected CRC-32
  function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [7:0] b);
    logic [31:0] r;
    r = crc ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `ETXD_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // ************************************************************
  // Controller
  // ************************************************************
  // Next state; one memory request at a time, held until mem_ack
  always_comb begin
    n         = c;
    ls        = c.w0[`ETXD_LS_BIT];
    issue     = !c.mem_req;
    done      = c.mem_req && mem_ack;
    sa_slot   = c.modify && (c.pos >= `ETXD_SA_POS) && (c.pos < `ETXD_SA_END);
    ins       = c.insert && sa_slot;
    fcs       = c.modify && ls && (c.remain <= `ETXD_FCS_LEN) && !ins;
    last      = ls && (c.remain == 13'h0001) && !ins;
    fcs_idx   = 2'(2'h0 - c.remain[1:0]);
    sa_idx    = 3'(c.pos[3:0] - 4'h6);
    sa_word   = c.sa_sel ? station_addr1 : station_addr0;
    sa_byte   = 8'(sa_word >> {sa_idx, 3'h0});
    lane_byte = 8'(c.word >> {c.buf_addr[1:0], 3'h0});
    crc_byte  = 8'(~c.crc >> {fcs_idx, 3'h0});
    // Replace overwrites bytes 6..11, insert pushes them ahead of buffer data
    out_byte  = sa_slot ? sa_byte : (fcs ? crc_byte : lane_byte);
    fin_valid = 1'b0;
    fin_data  = {last, out_byte};
    if (done) begin
      n.mem_req = 1'b0;
      n.mem_we  = 1'b0;
    end
    case (c.st)
      ST_IDLE: begin
        n.busy = 1'b0;
        if (start) begin
          n.desc_addr = desc_base;
          n.busy      = 1'b1;
          n.st        = ST_RD0;
        end
      end
      ST_RD0: begin
        if (issue) begin
          n.mem_req  = 1'b1;
          n.mem_addr = c.desc_addr + `ETXD_OFS_W0;
        end else if (done) begin
          n.w0   = mem_rdata;
          // A descriptor still held by software ends the chain
          n.st   = mem_rdata[`ETXD_OWN_BIT] ? ST_RD1 : ST_IDLE;
          n.busy = mem_rdata[`ETXD_OWN_BIT];
        end
      end
      ST_RD1: begin
        if (issue) begin
          n.mem_req  = 1'b1;
          n.mem_addr = c.desc_addr + `ETXD_OFS_W1;
        end else if (done) begin
          n.remain = mem_rdata[`ETXD_LEN_HI:0];
          n.word   = mem_rdata;
          n.st     = ST_RD2;
        end
      end
      ST_RD2: begin
        if (issue) begin
          n.mem_req  = 1'b1;
          n.mem_addr = c.desc_addr + `ETXD_OFS_W2;
        end else if (done) begin
          n.buf_addr = mem_rdata;
          n.st       = ST_RD3;
        end
      end
      ST_RD3: begin
        if (issue) begin
          n.mem_req  = 1'b1;
          n.mem_addr = c.desc_addr + `ETXD_OFS_W3;
        end else if (done) begin
          n.next_ptr = mem_rdata;
          // Mode is latched once per frame, at its first segment
          if (c.w0[`ETXD_FS_BIT]) begin
            n.sa_sel = c.word[`ETXD_SA_SEL_BIT];
            n.insert = (c.word[`ETXD_SA_MODE_HI:`ETXD_SA_MODE_LO] == `ETXD_SA_INSERT);
            n.modify = n.insert || (c.word[`ETXD_SA_MODE_HI:`ETXD_SA_MODE_LO] == `ETXD_SA_REPLACE);
            n.pos    = 16'h0000;
            n.crc    = `ETXD_CRC_INIT;
          end
          if (c.remain == 13'h0000) begin
            n.st = ls ? ST_STAMP : ST_WR0;
          end else begin
            n.st = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        if (issue) begin
          n.mem_req  = 1'b1;
          n.mem_addr = {c.buf_addr[31:2], 2'h0};
        end else if (done) begin
          n.word = mem_rdata;
          n.st   = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if ((c.remain == 13'h0000) && !ins) begin
          n.st = ls ? ST_STAMP : ST_WR0;
        end else begin
          fin_valid = 1'b1;
          if (fin_ready) begin
            // Old trailing CRC bytes are dropped, the new CRC goes out instead
            if (!fcs) begin
              n.crc = crc_step(c.crc, out_byte);
            end
            if (c.pos != `ETXD_POS_MAX) begin
              n.pos = c.pos + 16'h0001;
            end
            if (!ins) begin
              n.remain   = c.remain - 13'h0001;
              n.buf_addr = c.buf_addr + 32'h0000_0001;
              if ((c.buf_addr[1:0] == 2'h3) && (c.remain != 13'h0001)) begin
                n.st = ST_FETCH;
              end
            end
          end
        end
      end
      ST_STAMP: begin
        if (stamp_valid) begin
          n.stamp     = stamp_value;
          n.stamp_cap = stamp_ok;
          n.st        = stamp_ok ? ST_WR6 : ST_WR0;
        end
      end
      ST_WR6: begin
        if (issue) begin
          n.mem_req   = 1'b1;
          n.mem_we    = 1'b1;
          n.mem_addr  = c.desc_addr + `ETXD_OFS_W6;
          n.mem_wdata = c.stamp[31:0];
        end else if (done) begin
          n.st = ST_WR7;
        end
      end
      ST_WR7: begin
        if (issue) begin
          n.mem_req   = 1'b1;
          n.mem_we    = 1'b1;
          n.mem_addr  = c.desc_addr + `ETXD_OFS_W7;
          n.mem_wdata = c.stamp[63:32];
        end else if (done) begin
          n.st = ST_WR0;
        end
      end
      ST_WR0: begin
        if (issue) begin
          n.mem_req                    = 1'b1;
          n.mem_we                     = 1'b1;
          n.mem_addr                   = c.desc_addr + `ETXD_OFS_W0;
          n.mem_wdata                  = c.w0;
          n.mem_wdata[`ETXD_OWN_BIT]   = 1'b0;
          n.mem_wdata[`ETXD_STAMP_BIT] = c.stamp_cap;
        end else if (done) begin
          n.stamp_cap = 1'b0;
          n.desc_addr = c.next_ptr;
          n.st        = ST_RD0;
        end
      end
      default: begin
        n    = '0;
        n.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      c    <= '0;
      c.st <= ST_IDLE;
    end else begin
      c <= n;
    end
  end

  // ************************************************************
  // Data path to the transmitter
  // ************************************************************
  etxd_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (fin_valid),
    .in_ready  (fin_ready),
    .in_data   (fin_data),
    .out_valid (fout_valid),
    .out_ready (fout_ready),
    .out_data  (fout_data)
  );

  // Output register so every port leaves a flip-flop
  always_comb begin
    fout_ready = !o.valid || tx_ready;
    next_o     = o;
    if (fout_ready) begin
      next_o = {fout_valid, fout_data};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  assign tx_valid  = o.valid;
  assign tx_last   = o.last;
  assign tx_data   = o.data;
  assign busy      = c.busy;
  assign mem_req   = c.mem_req;
  assign mem_we    = c.mem_we;
  assign mem_addr  = c.mem_addr;
  assign mem_wdata = c.mem_wdata;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_done(etxd_state_t s);
    c.st == s && c.mem_req && mem_ack;
  endsequence

  chk_sa_select: assert property (s_done(ST_RD3) ##0 c.w0[`ETXD_FS_BIT] |=> c.sa_sel == c.word[31])
    else $error("source address select not latched");
  chk_sa_decode: assert property (s_done(ST_RD3) ##0 c.w0[`ETXD_FS_BIT]
    |=> c.insert == (c.word[30:29] == 2'h1) && c.modify == (c.word[30:29] inside {2'h1, 2'h2}))
    else $error("source address mode decoded wrongly");
  chk_fcs_subst: assert property (c.st == ST_EMIT && fin_valid && fin_ready && fcs
    |-> fin_data[7:0] == ~c.crc[8*fcs_idx +: 8] ##1 c.crc == $past(c.crc))
    else $error("crc byte not substituted");
  chk_fs_gate: assert property (s_done(ST_RD3) ##0 !c.w0[`ETXD_FS_BIT] |=> $stable({c.modify, c.insert, c.sa_sel}))
    else $error("mode changed outside first segment");
  chk_len_field: assert property (s_done(ST_RD1) |=> c.remain == $past(mem_rdata[12:0]))
    else $error("buffer length wrong");
  chk_zero_skip: assert property (s_done(ST_RD3) ##0 c.remain == 13'h0000 |=> c.st inside {ST_STAMP, ST_WR0})
    else $error("empty buffer not skipped");
  chk_buf_ptr: assert property (s_done(ST_RD2) |=> c.st == ST_RD3 && c.buf_addr == $past(mem_rdata))
    else $error("buffer address not taken");
  chk_next_ptr: assert property (s_done(ST_WR0) |=> c.st == ST_RD0 ##1 c.mem_req && c.mem_addr == $past(c.next_ptr, 2))
    else $error("chain pointer not followed");
  chk_stamp_low: assert property (c.st == ST_WR6 && c.mem_req
    |-> c.mem_we && c.mem_addr == c.desc_addr + 32'h18 && c.mem_wdata == c.stamp[31:0])
    else $error("low stamp word wrong");
  chk_stamp_high: assert property (s_done(ST_WR6) |-> ##2 c.st == ST_WR7 && c.mem_req
    && c.mem_addr == c.desc_addr + 32'h1C && c.mem_wdata == c.stamp[63:32])
    else $error("high stamp word wrong");
  chk_stamp_gate: assert property (c.st inside {ST_WR6, ST_WR7} |-> c.stamp_cap && c.w0[`ETXD_LS_BIT])
    else $error("stamp written without last segment and status");
endmodule : etxd_desc_engine

// File: testbench/etxd_mem_model.sv
// Memory model that holds descriptors and buffers and answers the engine's accesses
`timescale 1ns/100ps

// ************************************************************
// System memory
// ************************************************************
module etxd_mem_model (
  input  wire logic        clock,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] mem [bit [29:0]];
  logic [3:0]  wait_cnt;

  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 32'h0000_0000;
    wait_cnt  = 4'h0;
  end

  // One-cycle ack, at once or after four wait cycles; read data is not held after the ack
  always @(posedge clock) begin
    if (mem_req === 1'b1 && !mem_ack && wait_cnt >= (slow ? 4'h4 : 4'h0)) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem.exists(mem_addr[31:2]) ? mem[mem_addr[31:2]] : 32'h0000_0000;
      if (mem_we) mem[mem_addr[31:2]] = mem_wdata;
      wait_cnt  <= 4'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;  // Stale data must never look valid
      wait_cnt  <= (mem_req === 1'b1 && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : etxd_mem_model

// File: testbench/etxd_desc_engine_bench.sv
// Self-checking bench of the transmit descriptor engine
`timescale 1ns/100ps
`include "etxd_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("Error %0t: got %h expected %h", $time, a, b); end end

module etxd_desc_engine_bench;
  logic        clock, rst_n, start, busy, mem_req, mem_we, mem_ack, slow;
  logic [31:0] desc_base, mem_addr, mem_wdata, mem_rdata;
  logic [47:0] station_addr0, station_addr1;
  logic        stamp_valid, stamp_ok, tx_valid, tx_last, tx_ready;
  logic [63:0] stamp_value;
  logic [7:0]  tx_data;
  logic [8:0]  exp_q [$];
  logic [8:0]  exp_b;
  int          n_fail, n_tests, n_frames, cyc, f, k;

  etxd_desc_engine #(.FIFO_DEPTH(4)) etxd_desc_engine_inst (
    .clock(clock), .rst_n(rst_n), .start(start), .desc_base(desc_base), .busy(busy),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .station_addr0(station_addr0),
    .station_addr1(station_addr1), .stamp_valid(stamp_valid), .stamp_ok(stamp_ok),
    .stamp_value(stamp_value), .tx_valid(tx_valid), .tx_last(tx_last), .tx_data(tx_data),
    .tx_ready(tx_ready));

  etxd_mem_model etxd_mem_model_inst (
    .clock(clock), .slow(slow), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ************************************************************
  // Memory access and expected streams
  // ************************************************************
  function automatic logic [7:0] get_byte(input logic [31:0] a);
    return etxd_mem_model_inst.mem[a[31:2]][8*a[1:0] +: 8];
  endfunction : get_byte

  function automatic logic [31:0] get_word(input logic [31:0] a);
    return etxd_mem_model_inst.mem[a[31:2]];
  endfunction : get_word

  task automatic put_byte(input logic [31:0] a, input logic [7:0] b);
    if (!etxd_mem_model_inst.mem.exists(a[31:2])) etxd_mem_model_inst.mem[a[31:2]] = 32'h0000_0000;
    etxd_mem_model_inst.mem[a[31:2]][8*a[1:0] +: 8] = b;
  endtask : put_byte

  // Stamp words are preset so a write where none belongs shows up
  task automatic set_desc(input logic [31:0] a, w0, w1, w2, w3);
    etxd_mem_model_inst.mem[a[31:2]]        = w0;
    etxd_mem_model_inst.mem[a[31:2] + 30'h1] = w1;
    etxd_mem_model_inst.mem[a[31:2] + 30'h2] = w2;
    etxd_mem_model_inst.mem[a[31:2] + 30'h3] = w3;
    etxd_mem_model_inst.mem[a[31:2] + 30'h6] = 32'h5A5A_5A5A;
    etxd_mem_model_inst.mem[a[31:2] + 30'h7] = 32'hA5A5_A5A5;
  endtask : set_desc

  // Frame as it should leave: address inserted or replaced, old CRC swapped for a new one
  task automatic exp_frame(input logic [31:0] a, input int len, input logic [1:0] mode, input logic [47:0] sa);
    logic [7:0]  q [$];
    logic [31:0] crc;
    int          i, j;
    for (i = 0; i < len; i++) q.push_back(get_byte(a + i));
    if (mode == `ETXD_SA_INSERT) for (i = 5; i >= 0; i--) q.insert(6, sa[8*i +: 8]);
    if (mode == `ETXD_SA_REPLACE) for (i = 0; i < 6; i++) q[6+i] = sa[8*i +: 8];
    if (mode != `ETXD_SA_KEEP) begin
      q = q[0:$-4];
      crc = `ETXD_CRC_INIT;
      for (i = 0; i < q.size(); i++) begin
        crc ^= 32'(q[i]);
        for (j = 0; j < 8; j++) crc = crc[0] ? ((crc >> 1) ^ `ETXD_CRC_POLY) : (crc >> 1);
      end
      for (i = 0; i < 4; i++) q.push_back(~crc[8*i +: 8]);
    end
    for (i = 0; i < q.size(); i++) exp_q.push_back({i == q.size() - 1, q[i]});
  endtask : exp_frame

  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // ************************************************************
  // Clock, transmitter side and watchdog
  // ************************************************************
  initial clock = 1'b0;
  always #25 clock = ~clock;

  // The sink stalls at first so the FIFO fills, then takes four bytes of five
  always @(posedge clock) begin
    cyc++;
    tx_ready <= (cyc >= 40) && (cyc % 5 != 0);
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // Each byte taken is compared with the next expected byte and end flag
  always @(posedge clock) begin
    if (rst_n === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      exp_b = exp_q.size() ? exp_q.pop_front() : 9'h1FF;
      `CHK({tx_last, tx_data}, exp_b)
      if (tx_last === 1'b1) n_frames++;
    end
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    rst_n = 1'b0; start = 1'b0; desc_base = 32'h0000_0000; slow = 1'b0; tx_ready = 1'b0;
    stamp_valid = 1'b0; stamp_ok = 1'b0; stamp_value = 64'h0;
    station_addr0 = 48'h6655_4433_2211;
    station_addr1 = 48'hCCBB_AA99_8877;
    // Insert frame carries no source address, replace frame carries one
    for (k = 0; k < 12; k++) put_byte(32'h0000_1000 + k, k < 8 ? 8'hA0 + k : 8'hEE);
    for (k = 0; k < 4; k++) put_byte(32'h0000_2002 + k, 8'hB0 + k);
    for (k = 0; k < 18; k++) put_byte(32'h0000_4000 + k, k < 14 ? 8'hC0 + k : 8'hEE);
    set_desc(32'h0000_0100, 32'hB000_0000, 32'hA000_000C, 32'h0000_1000, 32'h0000_0140);
    set_desc(32'h0000_0140, 32'h9000_0000, 32'h0000_0000, 32'h0000_3000, 32'h0000_0180);
    // Reserved bits set and insert asked outside a first segment: both ignored
    set_desc(32'h0000_0180, 32'hA000_0000, 32'h3FFF_E004, 32'h0000_2002, 32'h0000_01C0);
    set_desc(32'h0000_01C0, 32'hB000_0000, 32'h4000_0012, 32'h0000_4000, 32'h0000_0200);
    set_desc(32'h0000_0200, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    exp_frame(32'h0000_1000, 12, `ETXD_SA_INSERT, station_addr1);
    exp_frame(32'h0000_2002, 4, `ETXD_SA_KEEP, station_addr1);
    exp_frame(32'h0000_4000, 18, `ETXD_SA_REPLACE, station_addr0);
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    start <= 1'b1;
    desc_base <= 32'h0000_0100;
    @(posedge clock);
    start <= 1'b0;
    // Stamp outcome reported after each frame; the later frames meet a slow memory
    for (f = 0; f < 3; f++) begin
      for (k = 0; k < 4000 && n_frames <= f; k++) @(posedge clock);
      repeat (2) @(posedge clock);
      stamp_valid <= 1'b1;
      stamp_ok    <= (f != 0);
      stamp_value <= (f == 1) ? 64'h1111_2222_3333_4444 : 64'h5555_6666_7777_8888;
      @(posedge clock);
      stamp_valid <= 1'b0;
      stamp_value <= ~stamp_value;
      slow        <= 1'b1;
    end
    for (k = 0; k < 4000 && busy !== 1'b0; k++) @(posedge clock);
    `CHK(busy, 1'b0)
    `CHK(exp_q.size(), 0)
    `CHK(get_word(32'h0000_0100), 32'h3000_0000)
    `CHK(get_word(32'h0000_0118), 32'h5A5A_5A5A)
    `CHK(get_word(32'h0000_011C), 32'hA5A5_A5A5)
    `CHK(get_word(32'h0000_0140), 32'h1000_0000)
    `CHK(get_word(32'h0000_0158), 32'h5A5A_5A5A)
    `CHK(get_word(32'h0000_0180), 32'h2002_0000)
    `CHK(get_word(32'h0000_0198), 32'h3333_4444)
    `CHK(get_word(32'h0000_019C), 32'h1111_2222)
    `CHK(get_word(32'h0000_01C0), 32'h3002_0000)
    `CHK(get_word(32'h0000_01D8), 32'h7777_8888)
    `CHK(get_word(32'h0000_01DC), 32'h5555_6666)
    finish_test();
  end
endmodule : etxd_desc_engine_bench
